// [hdl/mac_move.v]
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mac_move_defines.vh"

module mac_move (
  input wire clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg [7:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;
  reg [31:0] cmd_q;
  reg exec_q;
  reg [15:0] op1_q;
  reg [15:0] op2_q;
  reg [39:0] sum_register_40;
  reg [7:0] flags_q;
  reg [5:0] index_pointer;
  reg [5:0] ptr_offset_q;
  reg [5:0] ram_addr_q;
  reg sat_en_q;
  reg [15:0] dual_port_ram [0:63];

  // ----------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------
  wire [7:0] op_byte = cmd_q[15:8];
  wire [7:0] ptr_byte = cmd_q[23:16];
  wire prefix_ok = (cmd_q[7:0] == `PREFIX_BYTE);
  wire rnd = op_byte[0];
  reg op1_sgn;
  reg op2_sgn;
  reg is_rev;
  reg is_sub;
  reg known;

  always @* begin
    op1_sgn = 1'b0;
    op2_sgn = 1'b0;
    is_rev = 1'b0;
    is_sub = 1'b0;
    known = prefix_ok && (op_byte[3:1] == `OP_LOW_NIBBLE);
    case (op_byte[7:4])
      `OP_U_ADD: is_sub = 1'b0;
      `OP_U_SUB: begin
        is_sub = 1'b1;
        known = known && !rnd;
      end
      `OP_U_REV: is_rev = 1'b1;
      `OP_SU_ADD: op1_sgn = 1'b1;
      `OP_SU_SUB: begin
        op1_sgn = 1'b1;
        is_sub = 1'b1;
        known = known && !rnd;
      end
      `OP_SU_REV: begin
        op1_sgn = 1'b1;
        is_rev = 1'b1;
      end
      `OP_US_ADD: op2_sgn = 1'b1;
      `OP_US_REV: begin
        op2_sgn = 1'b1;
        is_rev = 1'b1;
      end
      default: known = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // multiply and combine
  // ----------------------------------------------------------------------
  // operands carry a 17th bit so one signed multiplier covers all signedness
  wire signed [16:0] mul_a = {op1_sgn & op1_q[15], op1_q};
  wire signed [16:0] mul_b = {op2_sgn & op2_q[15], op2_q};
  wire signed [33:0] product = mul_a * mul_b;
  // unsigned forms give product[33] = 0, so this is a zero extension there
  wire [39:0] prod40 = {{6{product[33]}}, product};
  wire [41:0] prod42 = {{2{prod40[39]}}, prod40};
  wire [41:0] acc42 = {{2{sum_register_40[39]}}, sum_register_40};
  wire [41:0] rnd42 = rnd ? `ROUND_CONST : 42'h000_0000_0000;
  reg [41:0] raw;
  reg [40:0] carry_sum;

  always @* begin
    if (is_rev) begin
      raw = prod42 - acc42 + rnd42;
      carry_sum = {1'b0, prod40} - {1'b0, sum_register_40};
    end else if (is_sub) begin
      raw = acc42 - prod42;
      carry_sum = {1'b0, sum_register_40} - {1'b0, prod40};
    end else begin
      raw = acc42 + prod42 + rnd42;
      carry_sum = {1'b0, sum_register_40} + {1'b0, prod40} + {1'b0, rnd42[39:0]};
    end
  end

  wire ovf = (raw[41:39] != 3'h0) && (raw[41:39] != 3'h7);
  wire do_sat = ovf && sat_en_q;
  wire [39:0] sat_val = raw[41] ? `SAT_NEG : `SAT_POS;
  wire [39:0] pre_clr = do_sat ? sat_val : raw[39:0];
  wire [39:0] result = rnd ? (pre_clr & `LOW_WORD_CLEAR) : pre_clr;
  wire guard_used = (result[39:31] != 9'h000) && (result[39:31] != 9'h1FF);

  // ----------------------------------------------------------------------
  // pointer modification for the move
  // ----------------------------------------------------------------------
  reg [5:0] ptr_next;

  always @* begin
    case (ptr_byte[1:0])
      `PTR_INC: ptr_next = index_pointer + 6'h01;
      `PTR_DEC: ptr_next = index_pointer - 6'h01;
      `PTR_OFFSET: ptr_next = index_pointer + ptr_offset_q;
      default: ptr_next = index_pointer;
    endcase
  end

  // ----------------------------------------------------------------------
  // bus write channel
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  reg wr_ok;

  always @* begin
    case (aw_addr_q)
      `OFS_CMD, `OFS_OPERANDS, `OFS_ACC_LO, `OFS_ACC_HI, `OFS_FLAGS,
      `OFS_POINTER, `OFS_RAM_ADDR, `OFS_RAM_DATA, `OFS_CONFIG: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  wire [31:0] wm = merge(32'h0000_0000, w_data_q, w_strb_q);
  wire wr_flags = do_write && (aw_addr_q == `OFS_FLAGS);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_addr_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      w_have_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers and execution
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= 32'h0000_0000;
      exec_q <= 1'b0;
      op1_q <= 16'h0000;
      op2_q <= 16'h0000;
      sum_register_40 <= 40'h00_0000_0000;
      flags_q <= 8'h00;
      index_pointer <= 6'h00;
      ptr_offset_q <= 6'h00;
      ram_addr_q <= 6'h00;
      sat_en_q <= 1'b0;
    end else begin
      exec_q <= do_write && (aw_addr_q == `OFS_CMD);
      // software clears flags by writing ones; an execute in the same cycle wins
      if (wr_flags) begin
        flags_q <= flags_q & ~wm[7:0];
      end
      if (do_write) begin
        case (aw_addr_q)
          `OFS_CMD: begin
            cmd_q <= merge(cmd_q, w_data_q, w_strb_q);
          end
          `OFS_OPERANDS: begin
            {op2_q, op1_q} <= merge({op2_q, op1_q}, w_data_q, w_strb_q);
          end
          `OFS_ACC_LO: begin
            sum_register_40[31:0] <= merge(sum_register_40[31:0], w_data_q, w_strb_q);
          end
          `OFS_ACC_HI: begin
            if (w_strb_q[0]) begin
              sum_register_40[39:32] <= w_data_q[7:0];
            end
          end
          `OFS_POINTER: begin
            if (w_strb_q[0]) begin
              index_pointer <= w_data_q[5:0];
            end
            if (w_strb_q[1]) begin
              ptr_offset_q <= w_data_q[13:8];
            end
          end
          `OFS_RAM_ADDR: begin
            if (w_strb_q[0]) begin
              ram_addr_q <= w_data_q[5:0];
            end
          end
          `OFS_CONFIG: begin
            if (w_strb_q[0]) begin
              sat_en_q <= w_data_q[0];
            end
          end
          default: begin
            sat_en_q <= sat_en_q;
          end
        endcase
      end
      if (exec_q && !known) begin
        flags_q[`FLG_ERR] <= 1'b1;
      end
      if (exec_q && known) begin
        sum_register_40 <= result;
        index_pointer <= ptr_next;
        flags_q[`FLG_V] <= ovf;
        if (do_sat) begin
          flags_q[`FLG_SL] <= 1'b1;
        end
        flags_q[`FLG_E] <= guard_used;
        if (ovf) begin
          flags_q[`FLG_SV] <= 1'b1;
        end
        flags_q[`FLG_C] <= carry_sum[40];
        flags_q[`FLG_Z] <= (result == 40'h00_0000_0000);
        flags_q[`FLG_N] <= result[39];
      end
    end
  end

  // ----------------------------------------------------------------------
  // data memory: move port and software port
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (exec_q && known) begin
      dual_port_ram[ptr_next] <= dual_port_ram[index_pointer];
    end else if (do_write && (aw_addr_q == `OFS_RAM_DATA) && (w_strb_q[1:0] == 2'h3)) begin
      dual_port_ram[ram_addr_q] <= w_data_q[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // bus read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  reg [31:0] rd_mux;
  reg rd_ok;

  always @* begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      `OFS_CMD: rd_mux = cmd_q;
      `OFS_OPERANDS: rd_mux = {op2_q, op1_q};
      `OFS_ACC_LO: rd_mux = sum_register_40[31:0];
      `OFS_ACC_HI: rd_mux = {24'h00_0000, sum_register_40[39:32]};
      `OFS_FLAGS: rd_mux = {24'h00_0000, flags_q};
      `OFS_POINTER: rd_mux = {18'h0_0000, ptr_offset_q, 2'h0, index_pointer};
      `OFS_RAM_ADDR: rd_mux = {26'h000_0000, ram_addr_q};
      `OFS_RAM_DATA: rd_mux = {16'h0000, dual_port_ram[ram_addr_q]};
      `OFS_CONFIG: rd_mux = {31'h0000_0000, sat_en_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [hdl/mac_move_defines.vh]
`ifndef MAC_MOVE_DEFINES_VH
`define MAC_MOVE_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_OPERANDS 8'h04
`define OFS_ACC_LO 8'h08
`define OFS_ACC_HI 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_POINTER 8'h14
`define OFS_RAM_ADDR 8'h18
`define OFS_RAM_DATA 8'h1C
`define OFS_CONFIG 8'h20

// ----------------------------------------------------------------------
// instruction bytes
// ----------------------------------------------------------------------
`define PREFIX_BYTE 8'h93
`define OP_U_ADD 4'h1
`define OP_U_SUB 4'h2
`define OP_U_REV 4'h3
`define OP_SU_ADD 4'h5
`define OP_SU_SUB 4'h6
`define OP_SU_REV 4'h7
`define OP_US_ADD 4'h9
`define OP_US_REV 4'hB
`define OP_LOW_NIBBLE 3'h4
`define PTR_KEEP 2'h0
`define PTR_INC 2'h1
`define PTR_DEC 2'h2
`define PTR_OFFSET 2'h3

// ----------------------------------------------------------------------
// arithmetic constants
// ----------------------------------------------------------------------
`define ROUND_CONST 42'h000_0000_8000
`define SAT_POS 40'h7F_FFFF_FFFF
`define SAT_NEG 40'h80_0000_0000
`define LOW_WORD_CLEAR 40'hFF_FFFF_0000

// ----------------------------------------------------------------------
// flag bit positions and bus answers
// ----------------------------------------------------------------------
`define FLG_N 0
`define FLG_Z 1
`define FLG_C 2
`define FLG_SV 3
`define FLG_E 4
`define FLG_SL 5
`define FLG_V 6
`define FLG_ERR 7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [tb/mac_move_checker.sv]
`timescale 1ns/1ps
module mac_move_checker (
  input wire clk,
  input wire rst_b,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // --
  // bus contract
  // --
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence both_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  b_answer_a: assert property (both_hs |=> ##1 s_axi_bvalid) else $error("write answer late");
  b_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer stuck");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid || s_axi_wvalid, 2))
    else $error("stray answer");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
    else $error("read answer moved");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
endmodule

bind mac_move mac_move_checker i_chk (.*);

// [tb/axi_lite_master.sv]
`timescale 1ns/1ps
module axi_lite_master (
  input wire clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  // --
  // handshakes judged on settled levels, released at the edge
  // --
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
    logic pa, pw, pb, ha, hw, hb, hv;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    pb = 1'h1;
    while (pa || pw || pb) begin
      @(negedge clk);
      ha = pa && s_axi_awready;
      hw = pw && s_axi_wready;
      hv = s_axi_bvalid;
      hb = hv && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      pa = pa && !ha;
      pw = pw && !hw;
      pb = pb && !hb;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      // ready follows the answer by one cycle so the slave must hold it
      s_axi_bready <= pb && hv;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic pa, pr, ha, hr, hv;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    pa = 1'h1;
    pr = 1'h1;
    while (pa || pr) begin
      @(negedge clk);
      ha = pa && s_axi_arready;
      hv = s_axi_rvalid;
      hr = hv && s_axi_rready;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      pa = pa && !ha;
      pr = pr && !hr;
      s_axi_arvalid <= pa;
      s_axi_rready <= pr && hv;
    end
  endtask
endmodule

// [tb/mac_move_tb.sv]
`timescale 1ns/1ps
`include "mac_move_defines.vh"
module mac_move_tb;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [39:0] acc = 40'h0;
  logic [7:0] fl = 8'h0;
  logic sat = 1'h0;
  logic [31:0] d;
  logic [1:0] r;
  mac_move i_dut (.*);
  axi_lite_master i_mst (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up;
    end
  end
  // --
  // helpers
  // --
  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_mst.wr(a, v, 4'hF, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_mst.rd(a, d, r);
    chk(d, e);
  endtask
  task automatic set_acc(input logic [39:0] v);
    acc = v;
    wr(`OFS_ACC_LO, v[31:0]);
    wr(`OFS_ACC_HI, {24'h0, v[39:32]});
  endtask
  // reference: expected sum and flags, then issue and compare
  task automatic run(input logic [7:0] op, input logic [15:0] a, input logic [15:0] b, input logic [1:0] pm);
    logic signed [16:0] sa, sb;
    logic signed [41:0] p, s, x;
    logic [40:0] cy;
    logic v, c;
    sa = {op[6] & a[15], a};
    sb = {op[7] & b[15], b};
    p = sa * sb;
    s = {{2{acc[39]}}, acc};
    x = op[5:4] == 2'h1 ? s + p : op[5:4] == 2'h2 ? s - p : p - s;
    if (op[0]) x = x + `ROUND_CONST;
    cy = {1'h0, acc} + {1'h0, p[39:0]} + (op[0] ? 41'h8000 : 41'h0);
    c = op[5:4] == 2'h1 ? cy[40] : op[5:4] == 2'h2 ? acc < p[39:0] : p[39:0] < acc;
    v = x[41:39] != 3'h0 && x[41:39] != 3'h7;
    if (v && sat) x[39:0] = x[41] ? `SAT_NEG : `SAT_POS;
    if (op[0]) x[15:0] = 16'h0;
    acc = x[39:0];
    fl[6:0] = {v, fl[5] | v & sat, acc[39:31] != 9'h0 && acc[39:31] != 9'h1FF, fl[3] | v, c, acc == 40'h0, acc[39]};
    wr(`OFS_OPERANDS, {b, a});
    wr(`OFS_CMD, {14'h0, pm, op, `PREFIX_BYTE});
    rd_chk(`OFS_ACC_LO, acc[31:0]);
    rd_chk(`OFS_ACC_HI, {24'h0, acc[39:32]});
    rd_chk(`OFS_FLAGS, {24'h0, fl});
  endtask
  // --
  // scenarios
  // --
  task automatic t_reset;
    logic [7:0] ofs [6] = '{`OFS_ACC_LO, `OFS_ACC_HI, `OFS_FLAGS, `OFS_POINTER, `OFS_RAM_ADDR, `OFS_CONFIG};
    foreach (ofs[i]) rd_chk(ofs[i], 32'h0);
  endtask
  task automatic t_ops;
    logic [7:0] ops [14] = '{8'h18, 8'h19, 8'h28, 8'h38, 8'h39, 8'h58, 8'h59, 8'h68, 8'h78, 8'h79, 8'h98, 8'h99,
      8'hB8, 8'hB9};
    set_acc(40'hFE_89AB_CDEF);
    foreach (ops[i]) run(ops[i], 16'h8001 + 16'(i) * 16'h1337, 16'hFFFE - 16'(i) * 16'h2469, 2'(i));
  endtask
  task automatic t_ovf;
    for (int k = 0; k < 2; k++) begin
      sat = k[0];
      wr(`OFS_CONFIG, {31'h0, sat});
      set_acc(`SAT_POS);
      run(8'h19, 16'hFFFF, 16'hFFFF, 2'h0);
      set_acc(`SAT_NEG);
      run(8'h28, 16'hFFFF, 16'hFFFF, 2'h0);
    end
    wr(`OFS_CONFIG, 32'h0);
    sat = 1'h0;
    set_acc(40'h0);
    run(8'h18, 16'h0, 16'h0, 2'h0);
  endtask
  task automatic t_move;
    logic [5:0] np;
    for (int m = 0; m < 4; m++) begin
      np = 6'h0A + 6'(m == 1) - 6'(m == 2) + (m == 3 ? 6'h05 : 6'h00);
      wr(`OFS_POINTER, 32'h0000_050A);
      wr(`OFS_RAM_ADDR, 32'h0000_000A);
      wr(`OFS_RAM_DATA, 32'h0000_A5A0 + 32'(m));
      run(8'h58, 16'h0003, 16'h0005, 2'(m));
      rd_chk(`OFS_POINTER, {18'h0, 6'h05, 2'h0, np});
      wr(`OFS_RAM_ADDR, {26'h0, np});
      rd_chk(`OFS_RAM_DATA, 32'h0000_A5A0 + 32'(m));
    end
  endtask
  task automatic t_bad;
    fl[7] = 1'h1;
    wr(`OFS_CMD, 32'h0000_1892);
    rd_chk(`OFS_FLAGS, {24'h0, fl});
    wr(`OFS_CMD, 32'h0000_2993);
    rd_chk(`OFS_ACC_LO, acc[31:0]);
    wr(`OFS_FLAGS, 32'h0000_00FF);
    rd_chk(`OFS_FLAGS, 32'h0);
    i_mst.wr(8'h40, 32'h1, 4'hF, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    rd_chk(8'h40, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    t_reset;
    t_ops;
    t_ovf;
    t_move;
    t_bad;
    wrap_up;
  end
endmodule
